// ===== hw/isda_params.svh
`ifndef ISDA_PARAMS_SVH
`define ISDA_PARAMS_SVH
// register offsets (16-bit register port, word index)
`define ISDA_LCD_BASE 8'h03
`define ISDA_LCD_LAST 8'h12
`define ISDA_LBD_BASE 8'h23
`define ISDA_LBD_LAST 8'h32
`define ISDA_BCD_BASE 8'h43
`define ISDA_BCD_LAST 8'h52
// field layout
`define ISDA_CHAN_W 8
`define ISDA_BIT_W 5
`define ISDA_REG_RESET 16'h0000
// channel delay limits per rate
`define ISDA_LIM_2M 8'h1f
`define ISDA_LIM_4M 8'h3f
`define ISDA_LIM_8M 8'h7f
`define ISDA_LIM_16M 8'hff
// quarter-bit length in system clocks at 16 Mb/s (rates below scale by 2,4,8)
`define ISDA_QTR_16M 2
`endif

// ===== hw/isda_pkg.sv
package isda_pkg;
  // stream rate selection
  typedef enum logic [1:0] {
    ISDA_RATE_2M,
    ISDA_RATE_4M,
    ISDA_RATE_8M,
    ISDA_RATE_16M
  } isda_rate_e;
  // receiver alignment state
  typedef enum logic [1:0] {
    ISDA_ST_WAIT_FRAME,
    ISDA_ST_HOLD_CHAN,
    ISDA_ST_STORE
  } isda_state_e;
  typedef logic [7:0] isda_addr_t;
  typedef logic [15:0] isda_data_t;
endpackage : isda_pkg

// ===== hw/isda_top.sv
`include "isda_params.svh"

// What this block does
// - sixteen local channel delay registers, 8-bit field in bits 7-0, rest reserved.
// - local stream data stored only after the programmed whole-channel count from frame.
// - channel delay limit 255/127/63/31 by rate; larger programmed values are clamped to it.
// - sixteen local bit delay registers, 5-bit field in bits 4-0, rest reserved.
// - local sample point moves forward by field times a quarter bit, max 7 3/4.
// - quarter-bit step scales with each stream's own rate, 2 to 16 Mb/s.
// - bit delay is linear; 19 gives four and three quarter bits.
// - sixteen backplane channel delay registers, 8-bit field in bits 7-0.
// - backplane stream data stored after its programmed channel count from frame.
module isda_top #(
  parameter int NSTREAM = 16,
  parameter int QTR_16M = `ISDA_QTR_16M
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // register port
  input wire isda_pkg::isda_addr_t reg_addr,
  input wire isda_pkg::isda_data_t reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output isda_pkg::isda_data_t reg_rdata,
  // frame pulse and per-stream rate
  input wire logic frame_pulse,
  input wire logic [2*NSTREAM-1:0] local_rate,
  input wire logic [2*NSTREAM-1:0] bkpl_rate,
  // serial inputs
  input wire logic [NSTREAM-1:0] local_serial_inputs,
  input wire logic [NSTREAM-1:0] bkpl_serial_inputs,
  // aligned bytes out, local then backplane stream order
  output logic [2*NSTREAM-1:0] out_valid,
  output logic [2*NSTREAM*8-1:0] out_data,
  input wire logic [2*NSTREAM-1:0] out_ready,
  // accepted by receiver (buffer not full)
  output logic [2*NSTREAM-1:0] rx_ready
);
  import isda_pkg::*;

  // ************************************************
  // registers
  // ************************************************
  logic [7:0] lcd_q [NSTREAM];
  logic [7:0] lcd_d [NSTREAM];
  logic [4:0] lbd_q [NSTREAM];
  logic [4:0] lbd_d [NSTREAM];
  logic [7:0] bcd_q [NSTREAM];
  logic [7:0] bcd_d [NSTREAM];
  isda_data_t rdata_q, rdata_d;

  // index within a bank, or -1 when outside
  function automatic int bank_idx(isda_addr_t a, isda_addr_t base, isda_addr_t last);
    int r;
    r = -1;
    if (a >= base && a <= last) begin
      r = int'(a - base);
    end
    return r;
  endfunction : bank_idx

  // register write and readback, reserved bits read zero
  always_comb begin
    int il, ib, ic;
    il = bank_idx(reg_addr, `ISDA_LCD_BASE, `ISDA_LCD_LAST);
    ib = bank_idx(reg_addr, `ISDA_LBD_BASE, `ISDA_LBD_LAST);
    ic = bank_idx(reg_addr, `ISDA_BCD_BASE, `ISDA_BCD_LAST);
    lcd_d = lcd_q;
    lbd_d = lbd_q;
    bcd_d = bcd_q;
    rdata_d = rdata_q;
    if (reg_wr) begin
      if (il >= 0) lcd_d[il] = reg_wdata[7:0];
      if (ib >= 0) lbd_d[ib] = reg_wdata[4:0];
      if (ic >= 0) bcd_d[ic] = reg_wdata[7:0];
    end
    if (reg_rd) begin
      rdata_d = `ISDA_REG_RESET;
      if (il >= 0) rdata_d = {8'h00, lcd_q[il]};
      if (ib >= 0) rdata_d = {11'h000, lbd_q[ib]};
      if (ic >= 0) rdata_d = {8'h00, bcd_q[ic]};
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < NSTREAM; i++) begin
        lcd_q[i] <= 8'h00;
        lbd_q[i] <= 5'h00;
        bcd_q[i] <= 8'h00;
      end
      rdata_q <= `ISDA_REG_RESET;
    end else begin
      lcd_q <= lcd_d;
      lbd_q <= lbd_d;
      bcd_q <= bcd_d;
      rdata_q <= rdata_d;
    end
  end
  assign reg_rdata = rdata_q;

  // ************************************************
  // input synchronisers
  // ************************************************
  logic [2*NSTREAM:0] sync1_q, sync2_q;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= {frame_pulse, bkpl_serial_inputs, local_serial_inputs};
      sync2_q <= sync1_q;
    end
  end

  // frame edge on synchronised pulse
  logic fp_prev_q;
  logic frame_edge;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) fp_prev_q <= 1'b0;
    else fp_prev_q <= sync2_q[2*NSTREAM];
  end
  assign frame_edge = sync2_q[2*NSTREAM] & ~fp_prev_q;

  // ************************************************
  // per-stream receivers
  // ************************************************
  genvar g;
  generate
    for (g = 0; g < 2*NSTREAM; g++) begin : g_rx
      localparam bit IS_LOCAL = (g < NSTREAM);
      localparam int SI = IS_LOCAL ? g : g - NSTREAM;
      isda_rate_e rate;
      logic [7:0] limit;
      logic [7:0] chan_live;
      logic [4:0] bit_live;
      logic [9:0] qlen;
      // per-frame captured delays
      logic [7:0] cdel_q, cdel_d;
      logic [4:0] bdel_q, bdel_d;
      isda_state_e st_q, st_d;
      logic [12:0] tick_q, tick_d;
      logic [7:0] chan_q, chan_d;
      logic [2:0] bitn_q, bitn_d;
      logic [7:0] sh_q, sh_d;
      logic push;
      // two-entry buffer
      logic [7:0] buf_q [2];
      logic [7:0] buf_d [2];
      logic [1:0] cnt_q, cnt_d;
      logic pop;

      assign rate = isda_rate_e'(IS_LOCAL ? local_rate[2*SI +: 2] : bkpl_rate[2*SI +: 2]);
      assign chan_live = IS_LOCAL ? lcd_q[SI] : bcd_q[SI];
      assign bit_live = IS_LOCAL ? lbd_q[SI] : 5'h00;

      // quarter-bit length and channel limit follow stream rate
      always_comb begin
        case (rate)
          ISDA_RATE_2M: begin
            qlen = 10'(QTR_16M * 8);
            limit = `ISDA_LIM_2M;
          end
          ISDA_RATE_4M: begin
            qlen = 10'(QTR_16M * 4);
            limit = `ISDA_LIM_4M;
          end
          ISDA_RATE_8M: begin
            qlen = 10'(QTR_16M * 2);
            limit = `ISDA_LIM_8M;
          end
          default: begin
            qlen = 10'(QTR_16M);
            limit = `ISDA_LIM_16M;
          end
        endcase
      end

      // frame alignment: count quarter bits, sample, count channels
      always_comb begin
        st_d = st_q;
        cdel_d = cdel_q;
        bdel_d = bdel_q;
        tick_d = tick_q;
        chan_d = chan_q;
        bitn_d = bitn_q;
        sh_d = sh_q;
        push = 1'b0;
        if (frame_edge) begin
          cdel_d = (chan_live > limit) ? limit : chan_live;
          bdel_d = bit_live;
          // sample at bit-delay quarters plus half bit
          tick_d = 13'(({8'h00, bit_live} + 13'd2) * {3'd0, qlen});
          chan_d = 8'h00;
          bitn_d = 3'd0;
          st_d = ISDA_ST_HOLD_CHAN;
        end else begin
          case (st_q)
            ISDA_ST_WAIT_FRAME: st_d = ISDA_ST_WAIT_FRAME;
            ISDA_ST_HOLD_CHAN, ISDA_ST_STORE: begin
              if (tick_q > 13'd1) begin
                tick_d = tick_q - 13'd1;
              end else begin
                tick_d = 13'({qlen, 2'b00}); // one bit period
                sh_d = {sh_q[6:0], sync2_q[g]};
                bitn_d = bitn_q + 3'd1;
                if (bitn_q == 3'd7) begin
                  // store only once the delay count is reached
                  if (st_q == ISDA_ST_STORE || chan_q >= cdel_q) begin
                    push = 1'b1;
                    st_d = ISDA_ST_STORE;
                  end
                  chan_d = chan_q + 8'h01;
                end
              end
            end
            default: st_d = ISDA_ST_WAIT_FRAME;
          endcase
        end
      end

      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          st_q <= ISDA_ST_WAIT_FRAME;
          cdel_q <= 8'h00;
          bdel_q <= 5'h00;
          tick_q <= 13'h0000;
          chan_q <= 8'h00;
          bitn_q <= 3'd0;
          sh_q <= 8'h00;
        end else begin
          st_q <= st_d;
          cdel_q <= cdel_d;
          bdel_q <= bdel_d;
          tick_q <= tick_d;
          chan_q <= chan_d;
          bitn_q <= bitn_d;
          sh_q <= sh_d;
        end
      end

      // two-entry buffer; a push into a full buffer is dropped
      assign pop = out_ready[g] && (cnt_q != 2'd0);
      always_comb begin
        buf_d = buf_q;
        cnt_d = cnt_q;
        if (pop) begin
          buf_d[0] = buf_q[1];
          cnt_d = cnt_d - 2'd1;
        end
        if (push && cnt_q != 2'd2) begin
          buf_d[cnt_d[0]] = {sh_q[6:0], sync2_q[g]};
          cnt_d = cnt_d + 2'd1;
        end
      end
      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          buf_q[0] <= 8'h00;
          buf_q[1] <= 8'h00;
          cnt_q <= 2'd0;
        end else begin
          buf_q <= buf_d;
          cnt_q <= cnt_d;
        end
      end
      assign out_valid[g] = (cnt_q != 2'd0);
      assign out_data[g*8 +: 8] = buf_q[0];
      assign rx_ready[g] = (cnt_q != 2'd2);
    end
  endgenerate
endmodule : isda_top

// ===== sim/isda_top_sva.sv
module isda_top_sva #(
  parameter int NSTREAM = 16
) (
  // clock, reset and register port
  input wire logic clk,
  input wire logic arst_n,
  input wire isda_pkg::isda_addr_t reg_addr,
  input wire isda_pkg::isda_data_t reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire isda_pkg::isda_data_t reg_rdata,
  // stream side
  input wire logic frame_pulse,
  input wire logic [2*NSTREAM-1:0] out_valid,
  input wire logic [2*NSTREAM*8-1:0] out_data,
  input wire logic [2*NSTREAM-1:0] out_ready,
  input wire logic [2*NSTREAM-1:0] rx_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic lcd, lbd, bcd, seen_q, seen_d;
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // which register bank the index falls in
  assign lcd = reg_addr inside {[8'h03:8'h12]};
  assign lbd = reg_addr inside {[8'h23:8'h32]};
  assign bcd = reg_addr inside {[8'h43:8'h52]};
  // remembers that a frame edge has come since reset
  always_comb seen_d = seen_q | frame_pulse;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) seen_q <= 1'b0;
    else seen_q <= seen_d;
  end
  AST_NO_EARLY: assert property (!seen_q |-> out_valid == '0)
    else $error("byte before frame");
  AST_UNMAPPED: assert property (reg_rd && !(lcd || lbd || bcd) |=> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  AST_LCD_RSV: assert property (reg_rd && lcd |=> reg_rdata[15:8] == 8'h00)
    else $error("local channel reserved bits set");
  AST_LBD_RSV: assert property (reg_rd && lbd |=> reg_rdata[15:5] == 11'h000)
    else $error("bit delay reserved bits set");
  AST_BCD_RSV: assert property (reg_rd && bcd |=> reg_rdata[15:8] == 8'h00)
    else $error("backplane reserved bits set");
  AST_WR_RD: assert property (reg_wr && lcd ##1 reg_rd && !reg_wr && $stable(reg_addr)
    |=> reg_rdata[7:0] == $past(reg_wdata[7:0], 2)) else $error("readback wrong");
  AST_RD_HOLD: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved");
  AST_FULL: assert property ((~rx_ready & ~out_valid) == '0)
    else $error("full buffer not valid");
  AST_STALL: assert property (out_valid[0] && !out_ready[0] |=> out_valid[0]
    && $stable(out_data[7:0])) else $error("stalled byte lost");
  AST_STALL_BK: assert property (out_valid[16] && !out_ready[16] |=> out_valid[16]
    && $stable(out_data[135:128])) else $error("stalled backplane byte lost");
  // main scenarios reached
  COV_LBD: cover property (reg_rd && lbd);
  COV_FULL: cover property (!rx_ready[0]);
  COV_BK: cover property (out_valid[16] && out_ready[16]);
endmodule : isda_top_sva

bind isda_top isda_top_sva #(.NSTREAM(NSTREAM)) u_sva (.clk, .arst_n, .reg_addr, .reg_wdata,
  .reg_wr, .reg_rd, .reg_rdata, .frame_pulse, .out_valid, .out_data, .out_ready, .rx_ready);

// ===== sim/isda_src.sv
module isda_src #(
  parameter int BITCYC = 8
) (
  // clock, start strobe and bit pattern
  input wire logic clk,
  input wire logic start,
  input wire logic [31:0] key,
  // frame pin and serial line
  output logic frame = 1'b0,
  output logic sd = 1'b1
);
  timeunit 1ns;
  timeprecision 1ps;
  int cyc = -1;
  logic st;
  // one bit per BITCYC clocks from the frame rise, msb of each channel first
  always @(posedge clk) begin
    st = start;
    #1;
    if (st) cyc = 0;
    else if (cyc >= 0) cyc = cyc + 1;
    frame = st || (cyc >= 0 && cyc < BITCYC);
    sd = (cyc < 0) ? 1'b1 : key[(cyc / BITCYC) % 32];
  end
endmodule : isda_src

// ===== sim/input_stream_delay_align_test.sv
module input_stream_delay_align_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int Q = 2;
  logic clk = 1'b0, arst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, start = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata, rnd_l = 16'h0000, rnd_b = 16'h0000;
  logic [31:0] local_rate = '0, bkpl_rate = '0, key = '0, out_valid, rx_ready, rr;
  logic [31:0] out_ready = '1;
  logic [255:0] out_data;
  logic frame_pulse, sd_l, sd_b, rd_pend = 1'b0;
  logic [1:0] rel = '0;
  logic [15:0] wv = 16'h0000;
  int failures = 0, n_checks = 0, seed = 86135, got[2] = '{0, 0};
  logic [15:0] rq[$];
  logic [7:0] sq[2][$];
  isda_top #(.NSTREAM(16), .QTR_16M(Q)) uut (.clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .frame_pulse, .local_rate, .bkpl_rate,
    .local_serial_inputs({rnd_l[15:1], sd_l}), .bkpl_serial_inputs({rnd_b[15:1], sd_b}),
    .out_valid, .out_data, .out_ready, .rx_ready);
  isda_src #(.BITCYC(4 * Q)) src_l (.clk, .start, .key, .frame(frame_pulse), .sd(sd_l));
  isda_src #(.BITCYC(8 * Q)) src_b (.clk, .start, .key, .frame(), .sd(sd_b));
  always #5 clk = ~clk;
  task automatic check(input logic [15:0] g, input logic [15:0] e, input string what);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, g, e);
    end
  endtask : check
  task automatic conclude();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : conclude
  // one register cycle; a read notes its expected answer
  task automatic acc(input logic wr, input logic [7:0] a, input logic [15:0] d, e);
    reg_wr <= wr;
    reg_rd <= !wr;
    reg_addr <= a;
    reg_wdata <= d;
    if (!wr) rq.push_back(e);
    @(posedge clk);
    #1;
  endtask : acc
  // byte the receiver should store for a channel, sample shifted by s bits
  function automatic logic [7:0] bits(input int ch, input int s);
    for (int j = 0; j < 8; j++) bits[7 - j] = key[(ch * 8 + s + j) % 32];
  endfunction : bits
  // reset, program delays, start one frame and wait for two bytes on each watched stream (local 0, backplane 0)
  task automatic run(input logic [7:0] cd, input logic [7:0] cb, input logic [4:0] bd);
    #1;
    arst_n <= 1'b0;
    rel = '0;
    got = '{0, 0};
    repeat (8) @(posedge clk);
    #1;
    arst_n <= 1'b1;
    key = $random(seed);
    acc(1'b1, 8'h03, {8'h00, cd}, 16'h0000);
    acc(1'b1, 8'h23, {11'h000, bd}, 16'h0000);
    acc(1'b1, 8'h43, {8'h00, cb}, 16'h0000);
    reg_wr <= 1'b0;
    start <= 1'b1;
    for (int i = 0; i < 2; i++) sq[0].push_back(bits(cd + i, (bd + 2) / 4));
    for (int i = 0; i < 2; i++) sq[1].push_back(bits(cb + i, 0));
    @(posedge clk);
    #1;
    start <= 1'b0;
    for (int t = 0; t < 40000 && got[0] + got[1] < 4; t++) @(posedge clk);
    check(16'(got[0] + got[1]), 16'h0004, "byte count");
  endtask : run
  // read answers come a cycle later; bytes count when valid meets ready
  always @(posedge clk) rd_pend <= reg_rd;
  always @(negedge clk) begin
    if (rd_pend) check(reg_rdata, rq.pop_front(), "read");
    for (int g = 0; g < 2; g++) begin
      if (out_valid[16 * g] && out_ready[16 * g]) begin
        got[g]++;
        check(out_data[128 * g +: 8], sq[g].pop_front(), "byte");
      end
    end
  end
  // random traffic; watched streams stall until their buffer fills, stop after two
  always @(posedge clk) begin
    #1;
    rr = $random(seed);
    for (int g = 0; g < 2; g++) rel[g] = rel[g] | (rx_ready[16 * g] === 1'b0);
    rr[0] = rel[0] && got[0] < 2;
    rr[16] = rel[1] && got[1] < 2;
    out_ready <= rr;
    rnd_l <= $random(seed);
    rnd_b <= $random(seed);
  end
  initial begin
    #1000000;
    failures++;
    $display("[ERR] %0t watchdog", $time);
    conclude();
  end
  initial begin
    local_rate = $random(seed) | 32'h0000_0003;
    bkpl_rate = ($random(seed) & 32'hffff_fffc) | 32'h0000_0002;
    repeat (8) @(posedge clk);
    #1;
    arst_n <= 1'b1;
    for (int i = 0; i < 51; i++) begin
      wv = 16'($random(seed));
      acc(1'b0, 8'h03 + 8'(i / 17 * 32) + 8'(i % 17), 16'h0000, 16'h0000);
      acc(1'b1, 8'h03 + 8'(i / 17 * 32) + 8'(i % 17), wv, 16'h0000);
      acc(1'b0, 8'h03 + 8'(i / 17 * 32) + 8'(i % 17), 16'h0000, (i % 17 == 16) ? 16'h0000
        : wv & ((i / 17 == 1) ? 16'h001f : 16'h00ff));
    end
    reg_rd <= 1'b0;
    run(8'h00, 8'h00, 5'h00);
    run(8'h05, 8'h02, 5'h04);
    run(8'h82, 8'h3f, 5'h13);
    run(8'hfe, 8'h7e, 5'h1f);
    conclude();
  end
endmodule : input_stream_delay_align_test
